/* rtl/sdbac_ctrl.sv */
// Host-side controller driving the SDRAM column access through its pins.
//
// The plain strobed port and the register offsets are this design's own decisions.
`default_nettype none
module sdbac_ctrl
    import sdbac_pkg::*;
#(
    parameter int DW = 16,
    parameter int RW = 11,
    parameter int CW = 8
) (
    input  wire logic          clk_in,
    input  wire logic          sys_rst_in,
    input  wire logic [3:0]    reg_addr_in,
    input  wire logic [31:0]   reg_wdata_in,
    input  wire logic          reg_wr_in,
    input  wire logic          reg_rd_in,
    output logic      [31:0]   reg_rdata_out,
    output logic               cs_n_out,
    output logic               ras_n_out,
    output logic               cas_n_out,
    output logic               we_n_out,
    output logic      [11:0]   addr_out,
    output logic               low_byte_mask_out,
    output logic               high_byte_mask_out,
    output logic      [DW-1:0] dq_out,
    output logic               dq_oe_out,
    input  wire logic [DW-1:0] dq_in
);
    logic [31:0]   cfg_q;
    logic [31:0]   addr_q;
    logic [DW-1:0] wdata_q;
    sdbac_state_t  state_q;
    sdbac_bank_t   bank_q [2];
    logic [3:0]    bank_tmr_q [2];
    logic [8:0]    beat_q;
    logic [8:0]    burst_len;
    logic [8:0]    rcount_q;
    logic [7:0]    pipe_q;
    logic [3:0]    dev_cmd;
    logic          cl3;
    logic          full_page;
    logic [2:0]    op;
    logic          cmd_wr;
    logic          busy;
    logic          issue;
    logic          use_ap;
    logic          ap_q;
    logic          cur_bank_q;
    logic          last_wr;
    logic          cap;
    logic          err_q;
    logic [1:0]    rmask_q;
    logic [DW-1:0] rbuf_rd;
    logic          rd_pending;

    assign cl3       = cfg_q[CFG_CL_BIT];
    assign full_page = (cfg_q[CFG_BL_LSB +: 3] == BL_FULL);
    assign op        = reg_wdata_in[CMD_OP_LSB +: 3];
    assign cmd_wr    = reg_wr_in && (reg_addr_in == CMD_OFS);
    assign busy      = (state_q != SDBAC_IDLE);

    always_comb begin
        unique case (cfg_q[CFG_BL_LSB +: 3])
            BL_1:    burst_len = 9'h001;
            BL_2:    burst_len = 9'h002;
            BL_4:    burst_len = 9'h004;
            BL_8:    burst_len = 9'h008;
            default: burst_len = FULL_PAGE_LEN;
        endcase
    end

    // A read or write is issued only to an active bank; new bursts may cut old ones.
    always_comb begin
        issue = 1'b0;
        if (cmd_wr) begin
            unique case (op)
                OP_ACT:   issue = (bank_q[reg_wdata_in[ADDR_BANK_BIT]] == SDBAC_BK_IDLE);
                OP_READ,
                OP_WRITE: issue = (bank_q[addr_q[ADDR_BANK_BIT]] == SDBAC_BK_ACT);
                OP_PRE:   issue = 1'b1;
                OP_STOP:  issue = busy;
                default:  issue = 1'b0;
            endcase
        end
    end

    assign use_ap = reg_wdata_in[CMD_AP_BIT] && !full_page;

    always_comb begin
        unique case (op)
            OP_ACT:   dev_cmd = DEV_ACT;
            OP_READ:  dev_cmd = DEV_READ;
            OP_WRITE: dev_cmd = DEV_WRITE;
            OP_PRE:   dev_cmd = DEV_PRE;
            OP_STOP:  dev_cmd = DEV_STOP;
            default:  dev_cmd = DEV_NOP;
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            cfg_q   <= CFG_RESET;
            addr_q  <= 32'h0000_0000;
            wdata_q <= '0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == CFG_OFS) cfg_q <= reg_wdata_in;
            if (reg_addr_in == ADDR_OFS) addr_q <= reg_wdata_in;
            if (reg_addr_in == WDATA_OFS) wdata_q <= reg_wdata_in[DW-1:0];
        end
    end

    // Device pins change only after a clock edge.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= DEV_NOP;
            addr_out <= 12'h000;
        end else if (issue) begin
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= dev_cmd;
            addr_out <= 12'h000;
            unique case (op)
                OP_ACT: begin
                    addr_out[RW-1:0]     <= reg_wdata_in[ADDR_ROW_LSB +: RW];
                    addr_out[BANK_SEL_BIT] <= reg_wdata_in[ADDR_BANK_BIT];
                end
                OP_PRE: begin
                    addr_out[PRE_ALL_BIT]  <= reg_wdata_in[CMD_ALL_BIT];
                    addr_out[BANK_SEL_BIT] <= addr_q[ADDR_BANK_BIT];
                end
                default: begin
                    addr_out[CW-1:0]       <= addr_q[ADDR_COL_LSB +: CW];
                    addr_out[AUTO_PRE_BIT] <= use_ap;
                    addr_out[BANK_SEL_BIT] <= addr_q[ADDR_BANK_BIT];
                end
            endcase
        end else begin
            {cs_n_out, ras_n_out, cas_n_out, we_n_out} <= DEV_NOP;
        end
    end

    // Burst sequencing; fixed bursts end by count, full page only by stop or precharge.
    assign last_wr = (state_q == SDBAC_WR) && !full_page && (beat_q == burst_len - 9'h001);
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            state_q    <= SDBAC_IDLE;
            beat_q     <= 9'h000;
            ap_q       <= 1'b0;
            cur_bank_q <= 1'b0;
        end else if (issue && (op == OP_READ || op == OP_WRITE)) begin
            state_q    <= (op == OP_READ) ? SDBAC_RD : SDBAC_WR;
            beat_q     <= 9'h000;
            ap_q       <= use_ap;
            cur_bank_q <= addr_q[ADDR_BANK_BIT];
        end else if (issue && (op == OP_STOP || op == OP_PRE)) begin
            state_q <= SDBAC_IDLE;
        end else if (busy) begin
            beat_q <= beat_q + 9'h001;
            if (!full_page && beat_q == burst_len - 9'h001) state_q <= SDBAC_IDLE;
        end
    end

    // Write data goes with the command and each following beat.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            dq_oe_out <= 1'b0;
            dq_out    <= '0;
        end else begin
            dq_oe_out <= issue && op == OP_WRITE ||
                         (state_q == SDBAC_WR && !last_wr && !(issue && op != OP_WRITE));
            dq_out    <= wdata_q;
        end
    end

    // Byte masks: write masks act at once, read masks two clocks ahead of the data.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            low_byte_mask_out  <= 1'b0;
            high_byte_mask_out <= 1'b0;
        end else if (issue && op == OP_WRITE) begin
            low_byte_mask_out  <= reg_wdata_in[CMD_MASK_LSB];
            high_byte_mask_out <= reg_wdata_in[CMD_MASK_LSB + 1];
        end else if (issue && op == OP_READ) begin
            low_byte_mask_out  <= reg_wdata_in[CMD_MASK_LSB];
            high_byte_mask_out <= reg_wdata_in[CMD_MASK_LSB + 1];
        end else if (rd_pending && state_q != SDBAC_RD) begin
            low_byte_mask_out  <= 1'b1;
            high_byte_mask_out <= 1'b1;
        end else if (!busy) begin
            low_byte_mask_out  <= 1'b0;
            high_byte_mask_out <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rmask_q <= 2'b00;
        end else if (issue && op == OP_READ) begin
            rmask_q <= reg_wdata_in[CMD_MASK_LSB +: 2];
        end
    end

    // Capture pipe: bit k marks data due k+1 clocks after a read beat was launched.
    assign rd_pending = |pipe_q;
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            pipe_q <= 8'h00;
        end else begin
            pipe_q <= {pipe_q[6:0], state_q == SDBAC_RD && !(issue && op == OP_WRITE)};
        end
    end
    assign cap = cl3 ? pipe_q[2] : pipe_q[1];

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            rcount_q <= 9'h000;
        end else if (issue && op == OP_READ) begin
            rcount_q <= 9'h000;
        end else if (cap && rcount_q != FULL_PAGE_LEN) begin
            rcount_q <= rcount_q + 9'h001;
        end
    end

    sdbac_rdbuf #(.DW(DW), .AW(CW)) u_rdbuf (
        .clk_in      (clk_in),
        .wr_en_in    (cap && rcount_q != FULL_PAGE_LEN),
        .wr_addr_in  (rcount_q[CW-1:0]),
        .wr_data_in  (dq_in),
        .rd_addr_in  (reg_wdata_in[CW-1:0]),
        .rd_data_out (rbuf_rd)
    );

    // Per-bank state and timers, auto precharge idles only its own bank.
    for (genvar b = 0; b < 2; b++) begin : g_bank
        always_ff @(posedge clk_in) begin
            if (sys_rst_in) begin
                bank_q[b]     <= SDBAC_BK_IDLE;
                bank_tmr_q[b] <= 4'h0;
            end else if (issue && op == OP_ACT && reg_wdata_in[ADDR_BANK_BIT] == b) begin
                bank_q[b]     <= SDBAC_BK_ACT;
                bank_tmr_q[b] <= 4'(RCD_CYC);
            end else if (issue && op == OP_PRE && (reg_wdata_in[CMD_ALL_BIT] || addr_q[ADDR_BANK_BIT] == b)) begin
                bank_q[b]     <= SDBAC_BK_PRE;
                bank_tmr_q[b] <= 4'(RP_CYC);
            end else if (ap_q && cur_bank_q == b && busy && !full_page && beat_q == burst_len - 9'h001) begin
                bank_q[b]     <= SDBAC_BK_PRE;
                bank_tmr_q[b] <= (state_q == SDBAC_WR) ? 4'(WRITE_AP_EXTRA_CYC + RP_CYC)
                               : 4'(RP_CYC + (cl3 ? 1 : 0));
            end else if (bank_tmr_q[b] != 4'h0) begin
                bank_tmr_q[b] <= bank_tmr_q[b] - 4'h1;
            end else if (bank_q[b] == SDBAC_BK_PRE) begin
                bank_q[b] <= SDBAC_BK_IDLE;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            err_q <= 1'b0;
        end else if (cmd_wr && !issue && op != OP_NONE) begin
            err_q <= 1'b1;
        end else if (reg_rd_in && reg_addr_in == STATUS_OFS) begin
            err_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            reg_rdata_out <= 32'h0000_0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                ADDR_OFS:   reg_rdata_out <= addr_q;
                WDATA_OFS:  reg_rdata_out <= 32'(wdata_q);
                CFG_OFS:    reg_rdata_out <= cfg_q;
                STATUS_OFS: reg_rdata_out <= {20'h0, err_q, rd_pending, bank_q[1], bank_q[0],
                                              state_q, 2'h0, rmask_q};
                RDATA_OFS:  reg_rdata_out <= 32'(rbuf_rd);
                RCOUNT_OFS: reg_rdata_out <= 32'(rcount_q);
                default:    reg_rdata_out <= 32'h0000_0000;
            endcase
        end else begin
            reg_rdata_out <= 32'h0000_0000;
        end
    end
endmodule // sdbac_ctrl
`default_nettype wire

/* pkg/sdbac_pkg.sv */
// Package of constants and types for the SDRAM burst access controller.
`default_nettype none
package sdbac_pkg;
    // Software register offsets, word addressed.
    localparam logic [3:0] CMD_OFS      = 4'h0;
    localparam logic [3:0] ADDR_OFS     = 4'h1;
    localparam logic [3:0] WDATA_OFS    = 4'h2;
    localparam logic [3:0] CFG_OFS      = 4'h3;
    localparam logic [3:0] STATUS_OFS   = 4'h4;
    localparam logic [3:0] RDATA_OFS    = 4'h5;
    localparam logic [3:0] RCOUNT_OFS   = 4'h6;
    // Command register bit positions.
    localparam int CMD_OP_LSB   = 0;
    localparam int CMD_AP_BIT   = 3;
    localparam int CMD_ALL_BIT  = 4;
    localparam int CMD_MASK_LSB = 8;
    // Address register field layout.
    localparam int ADDR_ROW_LSB  = 0;
    localparam int ADDR_COL_LSB  = 0;
    localparam int ADDR_BANK_BIT = 16;
    // Device address bit positions.
    localparam int PRE_ALL_BIT   = 10;
    localparam int AUTO_PRE_BIT  = 10;
    localparam int BANK_SEL_BIT  = 11;
    // Configuration register field layout and reset value.
    localparam int CFG_CL_BIT    = 0;
    localparam int CFG_BL_LSB    = 4;
    localparam logic [31:0] CFG_RESET = 32'h0000_0021;
    // Burst length codes.
    localparam logic [2:0] BL_1    = 3'h0;
    localparam logic [2:0] BL_2    = 3'h1;
    localparam logic [2:0] BL_4    = 3'h2;
    localparam logic [2:0] BL_8    = 3'h3;
    localparam logic [2:0] BL_FULL = 3'h7;
    localparam logic [8:0] FULL_PAGE_LEN = 9'h100;
    // Timing, in nanoseconds and derived cycles at 100 MHz.
    localparam int CLK_PERIOD_NS = 10;
    localparam int T_RP_NS       = 20;
    localparam int T_RCD_NS      = 20;
    localparam int RP_CYC        = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RCD_CYC       = (T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WRITE_RECOVERY_CYC = 1;
    localparam int WRITE_AP_EXTRA_CYC = 2;
    localparam int MASK_READ_DELAY    = 2;
    localparam int BUS_TURN_CYC       = 1;
    // Software opcodes.
    localparam logic [2:0] OP_NONE  = 3'h0;
    localparam logic [2:0] OP_ACT   = 3'h1;
    localparam logic [2:0] OP_READ  = 3'h2;
    localparam logic [2:0] OP_WRITE = 3'h3;
    localparam logic [2:0] OP_PRE   = 3'h4;
    localparam logic [2:0] OP_STOP  = 3'h5;
    // Device command pins {cs_n, ras_n, cas_n, we_n}.
    localparam logic [3:0] DEV_NOP   = 4'h7;
    localparam logic [3:0] DEV_ACT   = 4'h3;
    localparam logic [3:0] DEV_READ  = 4'h5;
    localparam logic [3:0] DEV_WRITE = 4'h4;
    localparam logic [3:0] DEV_PRE   = 4'h2;
    localparam logic [3:0] DEV_STOP  = 4'h6;
    typedef enum logic [1:0] {
        SDBAC_IDLE = 2'b00,
        SDBAC_RD   = 2'b01,
        SDBAC_WR   = 2'b11
    } sdbac_state_t;
    typedef enum logic [1:0] {
        SDBAC_BK_IDLE = 2'b00,
        SDBAC_BK_ACT  = 2'b01,
        SDBAC_BK_PRE  = 2'b11
    } sdbac_bank_t;
endpackage
`default_nettype wire

/* rtl/sdbac_rdbuf.sv */
// Read data buffer holding the words of one burst, registered read port.
`default_nettype none
module sdbac_rdbuf #(
    parameter int DW = 16,
    parameter int AW = 8
) (
    input  wire logic          clk_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_addr_in,
    input  wire logic [DW-1:0] wr_data_in,
    input  wire logic [AW-1:0] rd_addr_in,
    output logic      [DW-1:0] rd_data_out
);
    logic [DW-1:0] mem_q [0:(1<<AW)-1];

    always_ff @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_q[wr_addr_in] <= wr_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        rd_data_out <= mem_q[rd_addr_in];
    end
endmodule // sdbac_rdbuf
`default_nettype wire

/* bench/sdbac_ctrl_assertions.sv */
// Concurrent checks on the controller's device pins against commands from its register port.
`default_nettype none
module sdbac_ctrl_assertions
    import sdbac_pkg::*;
#(
    parameter int DW = 16
) (
    input wire logic          clk_in,
    input wire logic          sys_rst_in,
    input wire logic [3:0]    reg_addr_in,
    input wire logic [31:0]   reg_wdata_in,
    input wire logic          reg_wr_in,
    input wire logic          reg_rd_in,
    input wire logic [31:0]   reg_rdata_out,
    input wire logic          cs_n_out,
    input wire logic          ras_n_out,
    input wire logic          cas_n_out,
    input wire logic          we_n_out,
    input wire logic [11:0]   addr_out,
    input wire logic          low_byte_mask_out,
    input wire logic          high_byte_mask_out,
    input wire logic [DW-1:0] dq_out,
    input wire logic          dq_oe_out,
    input wire logic [DW-1:0] dq_in
);
    logic [31:0] addr_q;
    logic [31:0] wdata_q;
    logic [3:0]  pins;
    assign pins = {cs_n_out, ras_n_out, cas_n_out, we_n_out};
    // Shadow copies of the software address and write data registers.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            addr_q <= 32'h0;
        end else if (reg_wr_in && reg_addr_in == ADDR_OFS) begin
            addr_q <= reg_wdata_in;
        end
    end
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            wdata_q <= 32'h0;
        end else if (reg_wr_in && reg_addr_in == WDATA_OFS) begin
            wdata_q <= reg_wdata_in;
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    sequence s_cmd(logic [2:0] op);
        reg_wr_in && reg_addr_in == CMD_OFS && reg_wdata_in[2:0] == op;
    endsequence
    property p_act_addr;
        s_cmd(OP_ACT) |=> pins == DEV_NOP || addr_out == {$past(reg_wdata_in[16]), $past(reg_wdata_in[10:0])};
    endproperty
    property p_pre_scope;
        s_cmd(OP_PRE) |=> pins == DEV_PRE && addr_out[10] == $past(reg_wdata_in[4])
            && (addr_out[10] || addr_out[11] == addr_q[16]);
    endproperty
    property p_rd_addr;
        pins == DEV_READ |-> addr_out[7:0] == addr_q[7:0] && addr_out[11] == addr_q[16];
    endproperty
    property p_wr_data;
        pins == DEV_WRITE |-> dq_oe_out && dq_out == wdata_q[DW-1:0];
    endproperty
    property p_wr_mask;
        s_cmd(OP_WRITE) |=> pins == DEV_WRITE |-> {high_byte_mask_out, low_byte_mask_out} == $past(reg_wdata_in[9:8]);
    endproperty
    property p_oe_start;
        $rose(dq_oe_out) |-> pins == DEV_WRITE;
    endproperty
    property p_rd_release;
        pins == DEV_READ |=> !dq_oe_out;
    endproperty
    property p_pre_recover;
        pins == DEV_PRE |-> !dq_oe_out;
    endproperty
    a_act_addr: assert property (p_act_addr) else $error("active address wrong");
    a_pre_scope: assert property (p_pre_scope) else $error("precharge scope wrong");
    a_rd_addr: assert property (p_rd_addr) else $error("read address wrong");
    a_wr_data: assert property (p_wr_data) else $error("write data not driven");
    a_wr_mask: assert property (p_wr_mask) else $error("write mask wrong");
    a_oe_start: assert property (p_oe_start) else $error("bus driven without write");
    a_rd_release: assert property (p_rd_release) else $error("bus held after read");
    a_pre_recover: assert property (p_pre_recover) else $error("precharge during write data");
endmodule // sdbac_ctrl_assertions
`default_nettype wire

/* bench/sdbac_dev_model.sv */
// Behavioural two-bank memory device answering the controller's pins.
`default_nettype none
module sdbac_dev_model
    import sdbac_pkg::*;
(
    input  wire logic        clk_in,
    input  wire logic [3:0]  cmd_in,
    input  wire logic [11:0] addr_in,
    input  wire logic [1:0]  mask_in,
    input  wire logic [15:0] dq_in,
    input  wire logic        oe_in,
    input  wire logic [1:0]  cl_in,
    input  wire logic [8:0]  bl_in,
    output logic      [15:0] dq_out,
    output int               err_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [512];
    logic [15:0] pd [4];
    logic        pv [4];
    logic [1:0]  m1;
    logic [1:0]  m2;
    logic [15:0] prev;
    sdbac_bank_t st [2];
    int          tmr [2];
    int          rl, wl, ra, wa, apb, apt, b;
    logic        rap, wap, apg, ap;
    function automatic int nxt(int c);
        return (c & 256) | ((c & 255 & ~(int'(bl_in) - 1)) | (((c & 255) + 1) & (int'(bl_in) - 1)));
    endfunction
    initial begin
        foreach (mem[i]) mem[i] = '0;
        st = '{SDBAC_BK_IDLE, SDBAC_BK_IDLE};
        tmr = '{0, 0};
        pv = '{default: 1'b0};
        {rl, wl, err_out} = '0;
        apg = 1'b0;
        prev = '0;
    end
    always @(posedge clk_in) begin
        for (int i = 0; i < 2; i++) begin
            if (tmr[i] > 0) tmr[i]--;
            if (tmr[i] == 0 && st[i] == SDBAC_BK_PRE) st[i] = SDBAC_BK_IDLE;
        end
        if (apg) begin
            st[apb] = SDBAC_BK_PRE;
            tmr[apb] = RP_CYC + apt;
            apg = 1'b0;
        end
        b = addr_in[11];
        ap = addr_in[10] && bl_in != FULL_PAGE_LEN;
        case (cmd_in)
            DEV_ACT: begin
                if (st[b] != SDBAC_BK_IDLE) err_out++;
                st[b] = SDBAC_BK_ACT;
            end
            DEV_PRE: begin
                for (int i = 0; i < 2; i++) begin
                    if (addr_in[10] || b == i) begin
                        st[i] = SDBAC_BK_PRE;
                        tmr[i] = RP_CYC;
                    end
                end
            end
            DEV_READ, DEV_WRITE: begin
                if (st[b] != SDBAC_BK_ACT) err_out++;
                if (cmd_in == DEV_READ) begin
                    {ra, rl, rap, wl} = {b * 256 + addr_in[7:0], int'(bl_in), ap, 32'h0};
                end else begin
                    {wa, wl, wap, rl} = {b * 256 + addr_in[7:0], int'(bl_in), ap, 32'h0};
                end
            end
            DEV_STOP: begin
                rl = 0;
                wl = 0;
            end
            default: ;
        endcase
        if (wl > 0) begin
            if (!oe_in) err_out++;
            if (!mask_in[0]) mem[wa][7:0] = dq_in[7:0];
            if (!mask_in[1]) mem[wa][15:8] = dq_in[15:8];
            wl--;
            if (wl == 0 && wap) {apg, apb, apt} = {1'b1, wa / 256, 32'h1};
            wa = nxt(wa);
        end
        pv[1] <= rl > 0;
        pd[1] <= mem[ra];
        if (rl > 0) begin
            rl--;
            if (rl == 0 && rap) {apg, apb, apt} = {1'b1, ra / 256, 32'h0};
            ra = nxt(ra);
        end
        pv[2] <= pv[1];
        pv[3] <= pv[2];
        pd[2] <= pd[1];
        pd[3] <= pd[2];
        m1 <= mask_in;
        m2 <= m1;
        prev <= dq_out;
    end
    // A released bus shows a pattern that changes every cycle.
    always_comb begin
        dq_out = ~prev;
        if (pv[cl_in] && !m2[0]) dq_out[7:0] = pd[cl_in][7:0];
        if (pv[cl_in] && !m2[1]) dq_out[15:8] = pd[cl_in][15:8];
    end
endmodule // sdbac_dev_model
`default_nettype wire

/* bench/test_sdbac_ctrl.sv */
// Self-checking bench for the burst access controller against a memory model.
`default_nettype none
module test_sdbac_ctrl
    import sdbac_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_in, sys_rst_in, reg_wr_in, reg_rd_in, cs_n, ras_n, cas_n, we_n, lm, hm, oe, c3;
    logic [3:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, v, r, d, seed;
    logic [11:0] addr;
    logic [15:0] dq_o, dq_i;
    logic [15:0] mem_m [512];
    logic [1:0]  cl, msk;
    logic [8:0]  bl;
    int          dev_err, failures, compares, cyc, bank, col, blen, c;
    sdbac_ctrl u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(reg_addr_in),
        .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
        .cs_n_out(cs_n), .ras_n_out(ras_n), .cas_n_out(cas_n), .we_n_out(we_n), .addr_out(addr),
        .low_byte_mask_out(lm), .high_byte_mask_out(hm), .dq_out(dq_o), .dq_oe_out(oe), .dq_in(dq_i));
    sdbac_dev_model u_mem (.clk_in(clk_in), .cmd_in({cs_n, ras_n, cas_n, we_n}), .addr_in(addr),
        .mask_in({hm, lm}), .dq_in(dq_o), .oe_in(oe), .cl_in(cl), .bl_in(bl), .dq_out(dq_i), .err_out(dev_err));
    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 5000) begin
            failures++;
            finish_test();
        end
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic int nxt(int x, int n);
        return (x & ~(n - 1)) | ((x + 1) & (n - 1));
    endfunction
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] w);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= w;
        reg_wr_in <= 1'b1;
        @(posedge clk_in);
        reg_wr_in <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] n, output logic [31:0] q);
        @(posedge clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= {24'h0, n};
        reg_rd_in <= 1'b1;
        @(posedge clk_in);
        reg_rd_in <= 1'b0;
        #1;
        q = reg_rdata_out;
    endtask
    task automatic err_chk(input logic e);
        logic [31:0] s;
        rd(STATUS_OFS, 8'h0, s);
        chk({31'h0, s[11]}, {31'h0, e});
    endtask
    task automatic act(input logic bk);
        logic [31:0] q;
        q = rnd();
        wr(CMD_OFS, {15'h0, bk, 5'h0, q[7:0], OP_ACT});
    endtask
    task automatic finish_test();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        {seed, failures, compares, cyc} = {32'h0001_8494, 96'h0};
        foreach (mem_m[i]) mem_m[i] = '0;
        {reg_wr_in, reg_rd_in, reg_addr_in, reg_wdata_in} = '0;
        {cl, bl} = {2'h3, 9'h004};
        sys_rst_in = 1'b1;
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        rd(CFG_OFS, 8'h0, v);
        chk(v, CFG_RESET);
        wr(ADDR_OFS, 32'h0001_0005);
        wr(CMD_OFS, {29'h0, OP_READ});
        err_chk(1'b1);
        err_chk(1'b0);
        for (int k = 0; k < 8; k++) begin
            {r, d} = {rnd(), rnd()};
            {bank, col, msk, blen, c3} = {int'(r[0]), int'(r[15:8]), r[5:4], 32'h1 << (k % 4), k[2]};
            {cl, bl} = {c3 ? 2'h3 : 2'h2, 9'(blen)};
            wr(CFG_OFS, {25'h0, 1'b0, 2'(k), 3'h0, c3});
            act(bank[0]);
            wr(WDATA_OFS, d);
            wr(ADDR_OFS, {15'h0, bank[0], 8'h0, 8'(col)});
            wr(CMD_OFS, {22'h0, msk, 5'h0, OP_WRITE});
            c = col;
            for (int i = 0; i < blen; i++) begin
                if (!msk[0]) mem_m[bank * 256 + c][7:0] = d[7:0];
                if (!msk[1]) mem_m[bank * 256 + c][15:8] = d[15:8];
                c = nxt(c, blen);
            end
            repeat (blen + 2) @(posedge clk_in);
            wr(CMD_OFS, {28'h0, 1'b1, OP_READ});
            repeat (20) @(posedge clk_in);
            rd(RCOUNT_OFS, 8'h0, v);
            chk(v, 32'(blen));
            for (int i = 0; i < blen; i++) begin
                // The buffer's read port is registered, so the word index must stand a cycle before the strobe.
                rd(RDATA_OFS, 8'(i), v);
                rd(RDATA_OFS, 8'(i), v);
                chk(v, {16'h0, mem_m[bank * 256 + c]});
                c = nxt(c, blen);
            end
            $display("burst test %0d done", k);
        end
        act(1'b0);
        wr(CMD_OFS, {27'h0, 1'b1, 1'b0, OP_PRE});
        repeat (4) @(posedge clk_in);
        act(1'b0);
        act(1'b1);
        err_chk(1'b0);
        wr(ADDR_OFS, 32'h0);
        wr(CMD_OFS, {29'h0, OP_PRE});
        repeat (4) @(posedge clk_in);
        act(1'b1);
        err_chk(1'b1);
        act(1'b0);
        err_chk(1'b0);
        $display("precharge test done");
        wr(ADDR_OFS, 32'h0000_0003);
        wr(CMD_OFS, {28'h0, 1'b1, OP_WRITE});
        repeat (8) @(posedge clk_in);
        act(1'b0);
        err_chk(1'b1);
        repeat (16) @(posedge clk_in);
        act(1'b0);
        err_chk(1'b0);
        wr(CMD_OFS, {29'h0, OP_WRITE});
        wr(CMD_OFS, {29'h0, OP_READ});
        wr(CMD_OFS, {29'h0, OP_READ});
        repeat (20) @(posedge clk_in);
        // Full-page bursts end only by stop or precharge, and their auto precharge request leaves the bank active.
        {cl, bl} = {2'h3, FULL_PAGE_LEN};
        wr(CFG_OFS, 32'h0000_0071);
        wr(CMD_OFS, {28'h0, 1'b1, OP_WRITE});
        wr(CMD_OFS, {29'h0, OP_STOP});
        wr(CMD_OFS, {28'h0, 1'b1, OP_READ});
        wr(CMD_OFS, {29'h0, OP_STOP});
        err_chk(1'b0);
        repeat (8) @(posedge clk_in);
        rd(RCOUNT_OFS, 8'h0, v);
        chk(v, 32'h0000_0002);
        $display("full page test done");
        chk(32'(dev_err), 32'h0);
        $display("interval test done");
        finish_test();
    end
endmodule // test_sdbac_ctrl
bind sdbac_ctrl sdbac_ctrl_assertions #(.DW(DW)) u_chk (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .cs_n_out(cs_n_out), .ras_n_out(ras_n_out), .cas_n_out(cas_n_out),
    .we_n_out(we_n_out), .addr_out(addr_out), .low_byte_mask_out(low_byte_mask_out),
    .high_byte_mask_out(high_byte_mask_out), .dq_out(dq_out), .dq_oe_out(dq_oe_out), .dq_in(dq_in));
`default_nettype wire
